/* File: hw/bsu_top.sv */
// Barrel shifter unit datapath with result, exponent and status state.
// Assumes the decoder presents one operation per mclk with its options.
//
// Operation
// RULE1 - Overflow flag set when top mid bit differs from low eight top bits.
// RULE2 - Sign flag updated only by upper and upper-extended sign counts.
// RULE3 - Sign flag takes operand top bit, inverted under upper-extended overflow.
// RULE4 - Status flags written at cycle end, visible next cycle.
// RULE5 - Shifts touch only overflow; sign counts only sign; block detect neither.
// RULE6 - Forty-bit result in three words, fed back for merging.
// RULE7 - Array places operand at any of 57 positions in one cycle.
// RULE8 - Exponent register 16 bits; shifts use low 8; counts sign-extend.
// RULE9 - Block exponent low five bits signed, sign-extended to 16.
// RULE10 - Registers read at cycle start, written at cycle end.
// RULE11 - Control code is 8-bit signed; positive shifts left.
// RULE12 - Code from exponent, its negation for align, or immediate.
// RULE13 - Placement referenced to middle word upper, low word lower.
// RULE14 - Zeros fill right; extension bit fills left, chosen per op.
// RULE15 - Merge option ORs array output with current result.
// RULE16 - Parallel-transfer forms accept only a restricted operand set.
// RULE17 - Exponent registers writable and readable over memory buses.
// RULE18 - Lower align extends with zero; upper align extends with carry.
// RULE19 - Lower count uses stored sign, offset -16, writes only at -15.
// RULE20 - Upper-extended with overflow yields +1, else as upper mode.
// RULE21 - Block detect updates block exponent only when larger.
// RULE22 - Without merge, array output replaces all 40 result bits.
`timescale 1ns/1ps
`default_nettype none
module bsu_top import bsu_pkg::*; #(
    parameter int WW = BSU_WORD_W,
    parameter int RW = BSU_RES_W
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic op_valid,
    input wire bsu_op_e op,
    input wire bsu_mode_e mode,
    input wire logic merge_option,
    input wire logic use_imm,
    input wire logic [BSU_CODE_W-1:0] imm_code,
    input wire logic arith_ext,
    input wire logic par_xfer,
    input wire bsu_src_e src_sel,
    input wire logic [WW-1:0] operand,
    input wire logic alu_carry,
    input wire logic alu_overflow,
    input wire logic res_wr_low,
    input wire logic res_wr_mid,
    input wire logic res_wr_top,
    input wire logic [WW-1:0] res_wr_data,
    input wire logic se_wr,
    input wire logic sb_wr,
    input wire logic [WW-1:0] bus_wr_data,
    output logic [WW-1:0] result_low_word,
    output logic [WW-1:0] result_mid_word,
    output logic [WW-1:0] result_top_word,
    output logic [WW-1:0] shift_exponent,
    output logic [WW-1:0] block_exponent_reg,
    output logic [BSU_STAT_W-1:0] arith_status,
    output logic shift_overflow_flag,
    output logic src_reject
);
    logic [RW-1:0] res_r, res_nxt;
    logic [WW-1:0] se_r, se_nxt, sb_r, sb_nxt;
    logic sv_r, sv_nxt, ss_r, ss_nxt;
    logic signed [BSU_CODE_W-1:0] code, det_exp;
    logic hi_ref, ext_bit, det_sign, is_shift, do_op;
    logic [RW-1:0] placed, shaped;
    logic signed [BSU_BEXP_W-1:0] new_bexp, cur_bexp;

    default clocking bsu_cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // Restricted operand set in parallel-transfer forms [RULE16]
    always_comb begin
        src_reject = par_xfer && (src_sel == BSU_SRC_OTHER);
    end

    bsu_array #(.WW(WW), .RW(RW)) u_array (
        .operand(operand),
        .code(code),
        .hi_ref(hi_ref),
        .ext_bit(ext_bit),
        .placed(placed)
    );

    bsu_expdet #(.WW(WW)) u_expdet (
        .operand(operand),
        .mode(mode),
        .alu_overflow(alu_overflow),
        .sign_in(ss_r),
        .exp_out(det_exp),
        .sign_out(det_sign)
    );

    always_comb begin
        do_op = op_valid && !src_reject;
        is_shift = (op == BSU_OP_ARITH_SHIFT_OP) || (op == BSU_OP_LOGIC_SHIFT_OP) ||
            (op == BSU_OP_NORM);
        hi_ref = (mode != BSU_MODE_LO); // [RULE13]
        // Signed 8-bit code source [RULE11] [RULE12] [RULE8]
        if (use_imm) begin
            code = $signed(imm_code);
        end else if (op == BSU_OP_NORM) begin
            code = -$signed(se_r[BSU_CODE_W-1:0]);
        end else begin
            code = $signed(se_r[BSU_CODE_W-1:0]);
        end
        // Extension bit selection [RULE14] [RULE18]
        case (op)
            BSU_OP_ARITH_SHIFT_OP: ext_bit = arith_ext ? operand[WW-1] : 1'b0;
            BSU_OP_NORM: ext_bit = hi_ref ? alu_carry : 1'b0;
            default: ext_bit = 1'b0;
        endcase
        // Merge or replace [RULE15] [RULE22] [RULE6]
        shaped = merge_option ? (placed | res_r) : placed;
        // Block exponent compare on low five bits [RULE9] [RULE21]
        new_bexp = det_exp[BSU_BEXP_W-1:0];
        cur_bexp = sb_r[BSU_BEXP_W-1:0];
    end

    always_comb begin
        res_nxt = res_r;
        se_nxt = se_r;
        sb_nxt = sb_r;
        sv_nxt = sv_r;
        ss_nxt = ss_r;
        if (do_op) begin
            case (op)
                BSU_OP_ARITH_SHIFT_OP, BSU_OP_LOGIC_SHIFT_OP, BSU_OP_NORM: begin
                    res_nxt = shaped;
                    // Overflow only [RULE5] [RULE1]
                    sv_nxt = |({BSU_TOP_CHK{shaped[2*WW-1]}} ^
                        shaped[2*WW+BSU_TOP_CHK-1:2*WW]);
                end
                BSU_OP_EXP: begin
                    if (mode == BSU_MODE_LO) begin
                        if (se_r == BSU_SE_LO_TRIG) begin
                            se_nxt = WW'(det_exp); // [RULE19] [RULE8]
                        end
                    end else begin
                        se_nxt = WW'(det_exp); // [RULE8]
                        ss_nxt = det_sign; // [RULE2] [RULE3] [RULE5]
                    end
                end
                BSU_OP_BLOCK_SCALE_DETECT_OP: begin
                    if (new_bexp > cur_bexp) begin
                        sb_nxt = WW'(new_bexp); // [RULE21] [RULE9]
                    end
                end
                default: begin
                end
            endcase
        end
        // Memory-bus and register-file writes of the words [RULE17] [RULE6]
        if (res_wr_low) begin
            res_nxt[WW-1:0] = res_wr_data;
        end
        if (res_wr_mid) begin
            res_nxt[2*WW-1:WW] = res_wr_data;
        end
        if (res_wr_top) begin
            res_nxt[RW-1:2*WW] = res_wr_data[RW-2*WW-1:0];
        end
        if (se_wr) begin
            se_nxt = bus_wr_data;
        end
        if (sb_wr) begin
            sb_nxt = bus_wr_data;
        end
    end

    // State written at cycle end, read next cycle [RULE10] [RULE4]
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            res_r <= '0;
            se_r <= BSU_RST_WORD;
            sb_r <= BSU_RST_WORD;
            sv_r <= 1'b0;
            ss_r <= 1'b0;
        end else begin
            res_r <= res_nxt;
            se_r <= se_nxt;
            sb_r <= sb_nxt;
            sv_r <= sv_nxt;
            ss_r <= ss_nxt;
        end
    end

    always_comb begin
        result_low_word = res_r[WW-1:0];
        result_mid_word = res_r[2*WW-1:WW];
        result_top_word = {{(3*WW-RW){res_r[RW-1]}}, res_r[RW-1:2*WW]};
        shift_exponent = se_r;
        block_exponent_reg = sb_r;
        shift_overflow_flag = sv_r;
        arith_status = '0;
        arith_status[BSU_OVF_BIT] = sv_r; // [RULE1]
        arith_status[BSU_SIGN_BIT] = ss_r; // [RULE2]
    end

    a_ovf_flag_match: assert property (do_op && is_shift && // [RULE1]
        !res_wr_mid && !res_wr_top |=> sv_r ==
        |({BSU_TOP_CHK{res_r[2*WW-1]}} ^ res_r[2*WW+BSU_TOP_CHK-1:2*WW]))
        else $error("overflow flag wrong");
    a_sign_hold_lo: assert property (do_op && op == BSU_OP_EXP && // [RULE2]
        mode == BSU_MODE_LO |=> $stable(ss_r))
        else $error("sign flag changed in lower mode");
    a_sign_hix_load: assert property (do_op && op == BSU_OP_EXP && // [RULE3]
        mode == BSU_MODE_HIX |=>
        ss_r == ($past(operand[WW-1]) ^ $past(alu_overflow)))
        else $error("sign flag load wrong");
    a_shift_no_sign: assert property (do_op && is_shift |=> // [RULE5]
        $stable(ss_r)) else $error("shift changed sign flag");
    a_block_scale_detect_op_flags: assert property (do_op && // [RULE5]
        op == BSU_OP_BLOCK_SCALE_DETECT_OP |=> $stable(ss_r) && $stable(sv_r))
        else $error("block detect changed flags");
    a_hix_ovf_one: assert property (do_op && op == BSU_OP_EXP && // [RULE20]
        mode == BSU_MODE_HIX && alu_overflow && !se_wr |=>
        se_r == 16'h0001) else $error("overflow exponent not +1");
    a_lo_exp_guard: assert property (do_op && op == BSU_OP_EXP && // [RULE19]
        mode == BSU_MODE_LO && se_r != BSU_SE_LO_TRIG && !se_wr |=>
        $stable(se_r)) else $error("lower count wrote exponent");
    a_replace_noor: assert property (do_op && is_shift && // [RULE22]
        !merge_option && !res_wr_low && !res_wr_mid && !res_wr_top |=>
        res_r == $past(placed)) else $error("result not replaced");
    a_merge_or: assert property (do_op && is_shift && // [RULE15]
        merge_option && !res_wr_low && !res_wr_mid && !res_wr_top |=>
        res_r == ($past(placed) | $past(res_r))) else $error("merge wrong");
    a_bexp_grow: assert property (do_op && op == BSU_OP_BLOCK_SCALE_DETECT_OP && // [RULE21]
        !sb_wr |=>
        $signed(sb_r[BSU_BEXP_W-1:0]) >= $signed($past(cur_bexp)))
        else $error("block exponent shrank");

    a_sign_hi_load: assert property (do_op && op == BSU_OP_EXP && // [RULE3]
        mode == BSU_MODE_HI |=> ss_r == $past(operand[WW-1]))
        else $error("sign flag not operand msb");
    a_exp_no_ovf: assert property (do_op && op == BSU_OP_EXP |=> // [RULE5]
        $stable(sv_r)) else $error("sign count changed overflow flag");
    a_flag_idle: assert property (!do_op |=> // [RULE4]
        $stable(sv_r) && $stable(ss_r)) else $error("flags moved without op");
    a_reject_flags: assert property (op_valid && src_reject |=> // [RULE16]
        $stable(sv_r) && $stable(ss_r)) else $error("refused op moved flags");
    a_hi_exp_range: assert property (do_op && op == BSU_OP_EXP && // [RULE20]
        mode == BSU_MODE_HI && !se_wr |=>
        $signed(se_r) >= $signed(BSU_SE_LO_TRIG) &&
        $signed(se_r) <= $signed(BSU_RST_WORD))
        else $error("upper exponent out of range");
    a_lo_exp_range: assert property (do_op && op == BSU_OP_EXP && // [RULE19]
        mode == BSU_MODE_LO && se_r == BSU_SE_LO_TRIG && !se_wr |=>
        $signed(se_r) <= $signed(BSU_SE_LO_TRIG))
        else $error("lower exponent above offset range");
    a_lo_exp_first: assert property (do_op && op == BSU_OP_EXP && // [RULE19]
        mode == BSU_MODE_LO && se_r == BSU_SE_LO_TRIG && !se_wr &&
        operand[WW-1] != ss_r |=> se_r == BSU_SE_LO_TRIG)
        else $error("lower exponent offset wrong");
    a_se_sign_ext: assert property (do_op && op == BSU_OP_EXP && // [RULE8]
        mode != BSU_MODE_LO && !se_wr |=>
        se_r[WW-1:BSU_CODE_W] == {(WW-BSU_CODE_W){se_r[BSU_CODE_W-1]}})
        else $error("exponent not extended");
    a_sb_sign_ext: assert property (do_op && op == BSU_OP_BLOCK_SCALE_DETECT_OP && // [RULE9]
        !sb_wr && new_bexp > cur_bexp |=> sb_r[WW-1:BSU_BEXP_W] ==
        {(WW-BSU_BEXP_W){sb_r[BSU_BEXP_W-1]}})
        else $error("block exponent not extended");
    a_bexp_hold: assert property (do_op && op == BSU_OP_BLOCK_SCALE_DETECT_OP && // [RULE21]
        !sb_wr && new_bexp <= cur_bexp |=> $stable(sb_r))
        else $error("block exponent written though not larger");
    a_res_idle: assert property (!do_op && !res_wr_low && // [RULE10]
        !res_wr_mid && !res_wr_top |=> $stable(res_r))
        else $error("result changed without write");
    a_low_word_write: assert property (res_wr_low |=> // [RULE6]
        res_r[WW-1:0] == $past(res_wr_data))
        else $error("low word write lost");
    a_mid_word_write: assert property (res_wr_mid |=> // [RULE6]
        res_r[2*WW-1:WW] == $past(res_wr_data))
        else $error("middle word write lost");
    a_top_word_write: assert property (res_wr_top |=> // [RULE6]
        res_r[RW-1:2*WW] == $past(res_wr_data[RW-2*WW-1:0]))
        else $error("top word write lost");
    a_se_bus_write: assert property (se_wr |=> // [RULE17]
        se_r == $past(bus_wr_data)) else $error("exponent write lost");
    a_sb_bus_write: assert property (sb_wr |=> // [RULE17]
        sb_r == $past(bus_wr_data)) else $error("block exponent write lost");
    a_logic_shift_op_ext: assert property (op == BSU_OP_LOGIC_SHIFT_OP |-> // [RULE14]
        !ext_bit) else $error("logical shift extension not zero");
    a_norm_lo_ext: assert property (op == BSU_OP_NORM && // [RULE18]
        mode == BSU_MODE_LO |-> !ext_bit)
        else $error("lower align extension not zero");
    a_norm_hi_ext: assert property (op == BSU_OP_NORM && // [RULE18]
        mode != BSU_MODE_LO |-> ext_bit == alu_carry)
        else $error("upper align extension not carry");
    a_top_sign_ext: assert property (result_top_word[WW-1:RW-2*WW] // [RULE6]
        == {(3*WW-RW){result_top_word[RW-2*WW-1]}})
        else $error("top word not sign extended");
endmodule
`default_nettype wire

/* File: include/bsu_pkg.sv */
// Constants and types for the barrel shifter unit.
// Assumes a single core clock and a decoder that supplies one op per cycle.
package bsu_pkg;
    localparam int BSU_WORD_W = 16;
    localparam int BSU_RES_W = 40;
    localparam int BSU_CODE_W = 8;
    localparam int BSU_BEXP_W = 5;
    localparam int BSU_OVF_BIT = 7;
    localparam int BSU_SIGN_BIT = 8;
    localparam int BSU_STAT_W = 16;
    localparam int BSU_HI_BASE = 16;
    localparam int BSU_LO_BASE = 0;
    localparam int BSU_TOP_CHK = 8;
    localparam logic [7:0] BSU_LO_OFFSET = 8'h10;
    localparam logic [15:0] BSU_SE_LO_TRIG = 16'hfff1;
    localparam logic [7:0] BSU_EXP_OVF = 8'h01;
    localparam logic [15:0] BSU_RST_WORD = 16'h0000;

    typedef enum logic [2:0] {
        BSU_OP_NONE,
        BSU_OP_ARITH_SHIFT_OP,
        BSU_OP_LOGIC_SHIFT_OP,
        BSU_OP_NORM,
        BSU_OP_EXP,
        BSU_OP_BLOCK_SCALE_DETECT_OP
    } bsu_op_e;

    typedef enum logic [1:0] {
        BSU_MODE_HI,
        BSU_MODE_HIX,
        BSU_MODE_LO
    } bsu_mode_e;

    // Source selector for the shifter operand
    typedef enum logic [3:0] {
        BSU_SRC_SI,
        BSU_SRC_AR,
        BSU_SRC_MR2,
        BSU_SRC_MR1,
        BSU_SRC_MR0,
        BSU_SRC_SR2,
        BSU_SRC_SR1,
        BSU_SRC_SR0,
        BSU_SRC_OTHER
    } bsu_src_e;
endpackage

/* File: hw/bsu_array.sv */
// Shifter array: places a 16-bit operand anywhere in a 40-bit field.
// Assumes the caller supplies code, reference half and extension bit.
`timescale 1ns/1ps
`default_nettype none
module bsu_array import bsu_pkg::*; #(
    parameter int WW = BSU_WORD_W,
    parameter int RW = BSU_RES_W
) (
    input wire logic [WW-1:0] operand,
    input wire logic signed [BSU_CODE_W-1:0] code,
    input wire logic hi_ref,
    input wire logic ext_bit,
    output logic [RW-1:0] placed
);
    logic signed [9:0] lsb_pos;
    always_comb begin
        // Position of operand bit 0 inside the field [RULE7] [RULE13]
        lsb_pos = 10'(code) + (hi_ref ? 10'(BSU_HI_BASE) : 10'(BSU_LO_BASE));
    end
    genvar gi;
    generate
        for (gi = 0; gi < RW; gi++) begin : g_bit
            logic signed [9:0] idx;
            always_comb begin
                idx = 10'(gi) - lsb_pos;
            end
            // Zeros right, extension bit left [RULE14]
            assign placed[gi] = (idx < 0) ? 1'b0 :
                (idx >= 10'(WW)) ? ext_bit : operand[idx[3:0]];
        end
    endgenerate
endmodule
`default_nettype wire

/* File: hw/bsu_expdet.sv */
// Exponent detector: redundant sign-bit count of a 16-bit operand.
// Assumes stored sign flag supplied for lower-half detection.
`timescale 1ns/1ps
`default_nettype none
module bsu_expdet import bsu_pkg::*; #(
    parameter int WW = BSU_WORD_W
) (
    input wire logic [WW-1:0] operand,
    input wire bsu_mode_e mode,
    input wire logic alu_overflow,
    input wire logic sign_in,
    output logic signed [BSU_CODE_W-1:0] exp_out,
    output logic sign_out
);
    logic sgn;
    logic [BSU_CODE_W-1:0] cnt;
    logic run;
    always_comb begin
        sign_out = operand[WW-1] ^ (mode == BSU_MODE_HIX && alu_overflow); // [RULE3]
        sgn = (mode == BSU_MODE_LO) ? sign_in : operand[WW-1]; // [RULE19]
        cnt = '0;
        run = 1'b1;
        for (int i = WW - 1; i >= 0; i--) begin
            if (run && operand[i] == sgn) begin
                cnt = cnt + 8'h01;
            end else begin
                run = 1'b0;
            end
        end
        if (mode == BSU_MODE_LO) begin
            exp_out = BSU_CODE_W'(8'h01 - cnt - BSU_LO_OFFSET); // [RULE19]
        end else if (mode == BSU_MODE_HIX && alu_overflow) begin
            exp_out = $signed(BSU_EXP_OVF); // [RULE20]
        end else begin
            exp_out = BSU_CODE_W'(8'h01 - cnt); // [RULE20]
        end
    end
endmodule
`default_nettype wire

/* File: tb/bsu_rf_model.sv */
// Register file model that feeds the shifter operand.
// Assumes the bench writes entries and selects one per cycle.
`timescale 1ns/1ps
`default_nettype none
module bsu_rf_model import bsu_pkg::*; (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [3:0] wr_idx,
    input wire logic [15:0] wr_data,
    input wire bsu_src_e src_sel,
    output logic [15:0] operand
);
    logic [15:0] regs_r [16];
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 16; i++) begin
                regs_r[i] <= 16'h0000;
            end
        end else if (wr_en) begin
            regs_r[wr_idx] <= wr_data; // Written at cycle end
        end
    end
    // Entries 0 to 8, one per source selector value, may feed the shifter
    assign operand = regs_r[src_sel];
endmodule
`default_nettype wire

/* File: tb/barrel_shifter_unit_tb.sv */
// Random and directed bench for the barrel shifter unit.
// Assumes bsu_top ports as declared and a 10 MHz core clock.
`timescale 1ns/1ps
`default_nettype none
module barrel_shifter_unit_tb import bsu_pkg::*;;
    logic mclk = 1'b0, rst_n = 1'b0, op_valid = 1'b0, merge_option = 1'b0;
    logic use_imm = 1'b0, arith_ext = 1'b0, par_xfer = 1'b0;
    logic alu_carry = 1'b0, alu_overflow = 1'b0, se_wr = 1'b0, sb_wr = 1'b0;
    logic res_wr_low = 1'b0, res_wr_mid = 1'b0, res_wr_top = 1'b0;
    logic pw_en = 1'b0;
    logic [3:0] pw_idx = 4'h0;
    logic [7:0] imm_code = 8'h00;
    logic [15:0] res_wr_data = 16'h0000, bus_wr_data = 16'h0000;
    logic [15:0] pw_data = 16'h0000, operand;
    bsu_op_e op = BSU_OP_NONE;
    bsu_mode_e mode = BSU_MODE_HI;
    bsu_src_e src_sel = BSU_SRC_SI;
    logic [15:0] lo_w, mid_w, top_w, se_o, sb_o, stat_o;
    logic ovf_o, rej_o;
    logic [39:0] e_res = 40'h0;
    logic [15:0] e_se = 16'h0000, e_sb = 16'h0000;
    logic e_ov = 1'b0, e_ss = 1'b0;
    int fails = 0, cmp_count = 0;
    logic [31:0] seed = 32'd97131;
    always #50 mclk = ~mclk;
    bsu_rf_model i_bsu_rf_model (.mclk(mclk), .rst_n(rst_n), .wr_en(pw_en),
        .wr_idx(pw_idx), .wr_data(pw_data), .src_sel(src_sel),
        .operand(operand));
    bsu_top i_bsu_top (.mclk(mclk), .rst_n(rst_n), .op_valid(op_valid),
        .op(op), .mode(mode), .merge_option(merge_option),
        .use_imm(use_imm), .imm_code(imm_code), .arith_ext(arith_ext),
        .par_xfer(par_xfer), .src_sel(src_sel), .operand(operand),
        .alu_carry(alu_carry), .alu_overflow(alu_overflow),
        .res_wr_low(res_wr_low), .res_wr_mid(res_wr_mid),
        .res_wr_top(res_wr_top), .res_wr_data(res_wr_data), .se_wr(se_wr),
        .sb_wr(sb_wr), .bus_wr_data(bus_wr_data), .result_low_word(lo_w),
        .result_mid_word(mid_w), .result_top_word(top_w),
        .shift_exponent(se_o), .block_exponent_reg(sb_o),
        .arith_status(stat_o), .shift_overflow_flag(ovf_o),
        .src_reject(rej_o));
    function automatic logic [31:0] xs(logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [39:0] place(logic [15:0] v,
        logic signed [7:0] c, logic hi, logic x);
        logic [79:0] w;
        int s;
        w = {{64{x}}, v};
        s = int'(c) + (hi ? 16 : 0);
        if (s >= 0) w = w << s;
        else w = 80'($signed(w) >>> (-s));
        return w[39:0];
    endfunction
    function automatic int lead(logic [15:0] v, logic s);
        int n;
        n = 0;
        for (int i = 15; i >= 0; i--) if (v[i] == s && n == 15 - i) n++;
        return n;
    endfunction
    task check(input logic [47:0] got, input logic [47:0] want);
        cmp_count++;
        if (got !== want) begin
            fails++;
            $display("BAD t=%0t got=%h want=%h", $time, got, want);
        end
    endtask
    task model_step;
        logic [39:0] pl;
        logic signed [7:0] c;
        logic x;
        logic [7:0] d;
        check(rej_o, par_xfer && src_sel == BSU_SRC_OTHER);
        if (op_valid && !(par_xfer && src_sel == BSU_SRC_OTHER)) begin
            case (op)
                BSU_OP_ARITH_SHIFT_OP, BSU_OP_LOGIC_SHIFT_OP, BSU_OP_NORM: begin
                    c = use_imm ? imm_code :
                        (op == BSU_OP_NORM ? -e_se[7:0] : e_se[7:0]);
                    x = (op == BSU_OP_ARITH_SHIFT_OP) ? arith_ext & operand[15] :
                        (op == BSU_OP_NORM && mode != BSU_MODE_LO) & alu_carry;
                    pl = place(operand, c, mode != BSU_MODE_LO, x);
                    e_res = merge_option ? (e_res | pl) : pl;
                    e_ov = |(e_res[39:32] ^ {8{e_res[31]}});
                end
                BSU_OP_EXP: begin
                    if (mode == BSU_MODE_LO) begin
                        d = 8'(-15 - lead(operand, e_ss));
                        if (e_se == 16'hfff1) e_se = {{8{d[7]}}, d};
                    end else begin
                        if (mode == BSU_MODE_HIX && alu_overflow) d = 8'h01;
                        else d = 8'(1 - lead(operand, operand[15]));
                        e_ss = operand[15] ^ (mode == BSU_MODE_HIX & alu_overflow);
                        e_se = {{8{d[7]}}, d};
                    end
                end
                BSU_OP_BLOCK_SCALE_DETECT_OP: begin
                    d = 8'(1 - lead(operand, operand[15]));
                    if ($signed(d[4:0]) > $signed(e_sb[4:0]))
                        e_sb = {{11{d[4]}}, d[4:0]};
                end
                default: ;
            endcase
        end
        if (se_wr) e_se = bus_wr_data;
        if (sb_wr) e_sb = bus_wr_data;
        if (res_wr_low) e_res[15:0] = res_wr_data;
        if (res_wr_mid) e_res[31:16] = res_wr_data;
        if (res_wr_top) e_res[39:32] = res_wr_data[7:0];
    endtask
    // Compare at the negedge, then fold in the inputs now standing
    task tick;
        @(negedge mclk);
        check({top_w, mid_w, lo_w}, {{8{e_res[39]}}, e_res});
        check(se_o, e_se);
        check(sb_o, e_sb);
        check(stat_o, {7'h0, e_ss, e_ov, 7'h0});
        check(ovf_o, e_ov);
        model_step;
        @(posedge mclk);
    endtask
    task rand_drive;
        logic [31:0] r, q;
        bsu_op_e o;
        logic v;
        seed = xs(seed);
        r = seed;
        seed = xs(seed);
        q = seed;
        v = r[0] | r[1];
        o = bsu_op_e'(r[4:2] % 3'd6);
        op_valid <= v;
        op <= o;
        mode <= (o == BSU_OP_EXP) ? bsu_mode_e'(r[6:5] % 2'd3) :
            ((r[5] && o != BSU_OP_BLOCK_SCALE_DETECT_OP) ? BSU_MODE_LO : BSU_MODE_HI);
        use_imm <= r[7] & (o != BSU_OP_NORM);
        imm_code <= r[15:8];
        {alu_overflow, alu_carry, par_xfer, merge_option, arith_ext} <= r[20:16];
        src_sel <= bsu_src_e'(r[24:21] % 4'd9);
        pw_en <= 1'b1;
        pw_idx <= q[3:0];
        pw_data <= (q[5:4] == 2'b00) ? {16{q[6]}} : q[31:16];
        se_wr <= &q[9:7];
        sb_wr <= &q[13:11];
        bus_wr_data <= q[10] ? 16'hfff1 : q[31:16];
        {res_wr_low, res_wr_mid, res_wr_top} <= {3{!v}} & q[16:14];
        res_wr_data <= q[31:16] ^ r[31:16];
    endtask
    task give_verdict;
        if (fails == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #2000000;
        fails++;
        give_verdict;
    end
    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        se_wr <= 1'b1;
        bus_wr_data <= 16'hfffd;
        {pw_en, pw_idx, pw_data} <= {1'b1, 4'(BSU_SRC_SI), 16'h765d};
        tick;
        se_wr <= 1'b0;
        op_valid <= 1'b1;
        op <= BSU_OP_LOGIC_SHIFT_OP;
        mode <= BSU_MODE_LO;
        {pw_idx, pw_data} <= {4'(BSU_SRC_AR), 16'hb6a3};
        tick;
        op <= BSU_OP_ARITH_SHIFT_OP;
        mode <= BSU_MODE_HI;
        {merge_option, arith_ext} <= 2'b11;
        src_sel <= BSU_SRC_AR;
        tick;
        op_valid <= 1'b0;
        tick;
        @(negedge mclk);
        check({top_w, mid_w, lo_w}, 48'hffff_f6d4_6ecb);
        @(posedge mclk);
        for (int i = 0; i < 3000; i++) begin
            rand_drive;
            tick;
        end
        give_verdict;
    end
endmodule
`default_nettype wire
